// *** include/sasc_pins_if.sv ***
// synchronised data line level and bus events passed from the receiver to the controller
`timescale 1ns/10ps
interface sasc_pins_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda_s;
  modport rx   (output scl_rise, output scl_fall, output start, output stop, output sda_s);
  modport ctrl (input scl_rise, input scl_fall, input start, input stop, input sda_s);
endinterface

// *** include/sasc_pkg.sv ***
// constants, types and the contract of the sensor front-end serial control block
// Contract
// RULE1: master pulses clock once before first start
// RULE2: first access is reset; device accepts it
// RULE3: slave only, standard and fast rates
// RULE4: start, address, zero-two data bytes, stop
// RULE5: start is data falling while clock high
// RULE6: matching address acknowledged by data low
// RULE7: fixed slave address is 0x67
// RULE8: address bit 0 selects write or read
// RULE9: byte after address ack is register number
// RULE10: up to two parameter bytes, each acknowledged
// RULE11: stop is data rising while clock high
// RULE12: master returns clock high when done
// RULE13: channel 1 active after power-up
// RULE14: sub-addresses 0x10-0x1F select the channel
// RULE15: per-channel offsets, only active one applied
// RULE16: eight amplifier gain codes via serial writes
// RULE17: regulator selectable between 3 V and 2.65 V
// RULE18: option turns regulator off during sleep
// RULE19: current-sense mode routes regulator current out
// RULE20: sleep powers analog down, serial stays alive
// RULE21: sub-address 0x06 plus byte sets gain
// RULE22: 0x20-0x2F plus two bytes set offset
// RULE23: regulator defaults to 3 V at power-up
// RULE24: unassigned sub-addresses change nothing
// RULE25: reads return addressed register, msb first
// RULE26: reset command restores all power-up defaults
package sasc_pkg;

  // ****************************************
  // bus framing
  // ****************************************
  localparam logic [6:0] SLAVE_ADDR    = 7'h67;
  localparam logic [3:0] BYTE_BITS     = 4'h8;

  // ****************************************
  // sub-addresses
  // ****************************************
  localparam logic [7:0] SUB_RESET     = 8'h01;
  localparam logic [7:0] SUB_SLEEP     = 8'h02;
  localparam logic [7:0] SUB_WAKE      = 8'h03;
  localparam logic [7:0] SUB_REG_CFG   = 8'h04;
  localparam logic [7:0] SUB_ISENSE    = 8'h05;
  localparam logic [7:0] SUB_GAIN      = 8'h06;
  localparam logic [3:0] SUB_CH_NIB    = 4'h1;
  localparam logic [3:0] SUB_OFF_NIB   = 4'h2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int         REG_LOW_BIT   = 0;
  localparam int         REG_SLEEP_BIT = 1;
  localparam int         ISENSE_BIT    = 0;
  localparam int         OFF_SIGN_BIT  = 10;

  // ****************************************
  // values after reset
  // ****************************************
  localparam logic [3:0]  RST_CHANNEL  = 4'h0;
  localparam logic [2:0]  RST_GAIN     = 3'h0;
  localparam logic [10:0] RST_OFFSET   = 11'h000;
  localparam logic        RST_REG_LOW  = 1'b0;
  localparam logic        RST_REG_OFF  = 1'b0;
  localparam logic        RST_ISENSE   = 1'b0;
  localparam logic        RST_SLEEP    = 1'b0;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} sasc_state_t;
  typedef enum logic [1:0] {PH_ADDR, PH_SUB, PH_PARAM} sasc_phase_t;

  function automatic logic sasc_is_offset(input logic [7:0] sub);
    return sub[7:4] == SUB_OFF_NIB;
  endfunction

endpackage

// *** tb/sasc_host_model.sv ***
// serial master model driving the clock and data lines of the block
`timescale 1ns/10ps
module sasc_host_model (
  input  wire logic ref_clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // ****************************************
  // bus cycles
  // ****************************************
  // half bit in cycles, 8 for fast rate
  int hp = 8;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic q();
    repeat (hp / 2) @(negedge ref_clk);
  endtask
  task automatic half();
    repeat (hp) @(negedge ref_clk);
  endtask
  task automatic wake_pulse();
    scl = 1'b0;
    half();
    scl = 1'b1;
    half();
  endtask
  task automatic start();
    q();
    sda_low = 1'b0;
    q();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    q();
    sda_low = 1'b1;
    q();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask
  // data moves mid-low only, sampled just before the fall
  task automatic clk_bit(input logic low, output logic seen);
    q();
    sda_low = low;
    q();
    scl = 1'b1;
    half();
    seen = sda_line;
    scl = 1'b0;
  endtask
  // byte msb first, then the ninth clock
  task automatic put(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
    end
    clk_bit(1'b0, s);
    ack = ~s;
  endtask
  task automatic get(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, b[i]);
    end
    clk_bit(mack, s);
  endtask
endmodule // sasc_host_model

// *** tb/tb_top.sv ***
// self-checking bench for the sensor front-end serial control block
`timescale 1ns/10ps
module tb_top
  import sasc_pkg::*;
;
  logic        ref_clk;
  logic        rst_n;
  logic        ce;
  logic        scl;
  logic        host_low;
  logic        sda_out;
  logic        sda_oe;
  logic        ack;
  logic [3:0]  ch;
  logic [2:0]  gain;
  logic [10:0] off;
  logic        reg_low, reg_soff, reg_en, isel, pdn, init_done;
  logic [3:0]  sh_ch;
  logic [2:0]  sh_gain;
  logic [10:0] sh_off [16];
  logic        sh_low, sh_soff, sh_sleep, sh_isel, sh_init;
  logic [7:0]  una [4] = '{8'h00, 8'h07, 8'h30, 8'hFF};
  logic [7:0]  rb;
  logic [10:0] v;
  int          errors;
  int          num_checks;
  int          seed = 32'h6b0ed8b5;
  wire         sda_w = ~(sda_oe | host_low);
  wire  [31:0] seen_vec = {6'h00, sda_oe, sda_out, ch, gain, off, reg_low, reg_soff, reg_en,
                           isel, pdn, init_done};
  sasc_serial_ctrl u_dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe(sda_oe), .active_channel(ch),
    .programmable_gain_amp_code(gain), .active_offset(off),
    .bridge_supply_regulator_low(reg_low), .bridge_supply_regulator_sleep_off(reg_soff),
    .bridge_supply_regulator_en(reg_en), .current_sense_sel(isel),
    .analog_power_down(pdn), .init_done(init_done)
  );
  sasc_host_model u_host (.ref_clk(ref_clk), .sda_line(sda_w), .scl(scl), .sda_low(host_low));
  // ****************************************
  // checking and bus tasks
  // ****************************************
  function automatic logic [31:0] exp_vec();
    return {8'h00, sh_ch, sh_gain, sh_off[sh_ch], sh_low, sh_soff, ~(sh_sleep & sh_soff),
            sh_isel, sh_sleep, sh_init};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic ak(input logic e);
    chk({31'h0, ack}, {31'h0, e});
  endtask
  task automatic defaults();
    sh_ch = 4'h0;
    sh_gain = 3'h0;
    sh_low = 1'b0;
    sh_soff = 1'b0;
    sh_sleep = 1'b0;
    sh_isel = 1'b0;
    foreach (sh_off[i]) sh_off[i] = 11'h000;
  endtask
  task automatic wr(input logic [7:0] sub, input int n, input logic [15:0] par);
    u_host.start();
    u_host.put(8'hCE, ack);
    ak(1'b1);
    u_host.put(sub, ack);
    ak(1'b1);
    for (int i = n; i > 0; i--) begin
      u_host.put(par[i*8-1 -: 8], ack);
      ak(1'b1);
    end
    u_host.stop();
    chk(seen_vec, exp_vec());
  endtask
  task automatic rd(input logic [7:0] sub, input int n, input logic [23:0] exp);
    u_host.start();
    u_host.put(8'hCE, ack);
    ak(1'b1);
    u_host.put(sub, ack);
    ak(1'b1);
    u_host.start();
    u_host.put(8'hCF, ack);
    ak(1'b1);
    for (int i = n; i > 0; i--) begin
      u_host.get(i > 1, rb);
      chk({24'h0, rb}, {24'h0, exp[i*8-1 -: 8]});
    end
    u_host.stop();
  endtask
  task automatic report_and_stop();
    if (errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #300us;
    errors++;
    report_and_stop();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    errors = 0;
    num_checks = 0;
    sh_init = 1'b0;
    defaults();
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(seen_vec, exp_vec());
    u_host.wake_pulse();
    sh_init = 1'b1;
    wr(8'h01, 0, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      v = (c == 0) ? 11'h7FF : (c == 15) ? 11'h400 : 11'($random(seed));
      sh_off[c] = v;
      wr(8'h20 | 8'(c), 2, {5'h00, v});
    end
    rb = 8'($random(seed));
    for (int i = 0; i < 16; i++) begin
      sh_ch = 4'(i) ^ rb[3:0];
      wr({4'h1, sh_ch}, 0, 16'h0000);
    end
    // a lone first offset byte commits nothing
    wr({4'h2, sh_ch}, 1, 16'h0007);
    for (int g = 0; g < 8; g++) begin
      rb = 8'($random(seed));
      sh_gain = 3'(g);
      u_host.hp = (g == 7) ? 16 : 8;
      wr(8'h06, 1, {8'h00, rb[7:3], sh_gain});
    end
    u_host.hp = 8;
    rd(8'h06, 2, {8'h00, 5'h00, sh_gain, 8'h00});
    rd({4'h2, sh_ch}, 3, {5'h00, sh_off[sh_ch], 8'h00});
    u_host.start();
    u_host.put(8'hCC, ack);
    ak(1'b0);
    u_host.put(8'h12, ack);
    ak(1'b0);
    u_host.stop();
    chk(seen_vec, exp_vec());
    sh_low = 1'b1;
    wr(8'h04, 1, 16'h0001);
    sh_low = 1'b0;
    sh_soff = 1'b1;
    wr(8'h04, 1, 16'h0002);
    sh_sleep = 1'b1;
    wr(8'h02, 0, 16'h0000);
    sh_gain = 3'h5;
    wr(8'h06, 1, 16'h0005);
    sh_sleep = 1'b0;
    wr(8'h03, 0, 16'h0000);
    sh_isel = 1'b1;
    wr(8'h05, 1, 16'h0001);
    rd({4'h1, sh_ch}, 2, {8'h00, 4'h0, sh_ch, 8'h00});
    rd(8'h04, 1, {16'h0000, 6'h00, sh_soff, sh_low});
    rd(8'h05, 1, {16'h0000, 7'h00, sh_isel});
    foreach (una[i]) wr(una[i], 2, 16'($random(seed)));
    sh_sleep = 1'b1;
    wr(8'h02, 0, 16'h0000);
    defaults();
    wr(8'h01, 0, 16'h0000);
    // clock enable low: the bus goes unseen and nothing moves
    ce = 1'b0;
    u_host.start();
    u_host.put(8'hCE, ack);
    ak(1'b0);
    u_host.put(8'h02, ack);
    ak(1'b0);
    u_host.stop();
    ce = 1'b1;
    chk(seen_vec, exp_vec());
    sh_ch = 4'h4;
    wr(8'h14, 0, 16'h0000);
    // second reset in mid-run from a non-default state
    sh_init = 1'b0;
    defaults();
    rst_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(seen_vec, exp_vec());
    u_host.wake_pulse();
    sh_init = 1'b1;
    wr(8'h01, 0, 16'h0000);
    report_and_stop();
  end
endmodule // tb_top

// *** verilog/sasc_bit_rx.sv ***
// line synchroniser and start, stop and clock edge detector
`timescale 1ns/10ps
module sasc_bit_rx
  import sasc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic scl_in,
  input  wire logic sda_in,
  sasc_pins_if.rx   pins
);

  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic       scl_d;
  logic       sda_d;

  // ****************************************
  // synchronisers
  // ****************************************
  // RULE12: idle lines assumed high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
    end else if (ce) begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
    end
  end

  // ****************************************
  // events
  // ****************************************
  // RULE3: oversampling covers both bit rates
  assign pins.scl_rise = scl_sync[1] & ~scl_d;
  assign pins.scl_fall = ~scl_sync[1] & scl_d;
  // RULE5: data falls while clock high
  assign pins.start    = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  // RULE11: data rises while clock high
  assign pins.stop     = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign pins.sda_s    = sda_sync[1];

endmodule // sasc_bit_rx

// *** verilog/sasc_serial_ctrl.sv ***
// two-wire slave controlling channel, gain, offsets, regulator and sleep
`timescale 1ns/10ps
module sasc_serial_ctrl
  import sasc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic [3:0]       active_channel,
  output logic [2:0]       programmable_gain_amp_code,
  output logic [10:0]      active_offset,
  output logic             bridge_supply_regulator_low,
  output logic             bridge_supply_regulator_sleep_off,
  output logic             bridge_supply_regulator_en,
  output logic             current_sense_sel,
  output logic             analog_power_down,
  output logic             init_done
);

  sasc_pins_if pins ();

  sasc_bit_rx u_rx (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .pins    (pins.rx)
  );

  sasc_state_t state;
  sasc_phase_t phase;
  logic [3:0]  bit_cnt;
  logic [7:0]  shift;
  logic [7:0]  tx_sh;
  logic        rw;
  logic [7:0]  sub;
  logic [1:0]  param_idx;
  logic [7:0]  pbuf;
  logic [1:0]  rd_idx;
  logic        mack;
  logic [10:0] offset_mem [16];
  logic [7:0]  rd_byte;
  logic [1:0]  rd_sel;
  logic        byte_done;
  logic        addr_hit;
  logic        sub_done;
  logic        par_done;
  logic        reset_cmd;

  // ****************************************
  // byte events
  // ****************************************
  assign byte_done = ce && state == ST_RX && bit_cnt == BYTE_BITS && pins.scl_fall
                     && !pins.start && !pins.stop;
  // RULE7: fixed address compare
  assign addr_hit  = shift[7:1] == SLAVE_ADDR;
  // RULE9: byte after address is the register number
  assign sub_done  = byte_done && phase == PH_SUB;
  assign par_done  = byte_done && phase == PH_PARAM;
  // RULE2: reset command accepted at any time, first included
  assign reset_cmd = sub_done && shift == SUB_RESET;

  // ****************************************
  // read data selection
  // ****************************************
  assign rd_sel = (state == ST_MACK) ? ((rd_idx == 2'h3) ? rd_idx : rd_idx + 2'h1) : 2'h0;

  // RULE25: contents of last addressed register
  always_comb begin
    rd_byte = 8'h00;
    if (sub[7:4] == SUB_CH_NIB && rd_sel == 2'h0) begin
      rd_byte = {4'h0, active_channel};
    end else if (sub == SUB_GAIN && rd_sel == 2'h0) begin
      rd_byte = {5'h00, programmable_gain_amp_code};
    end else if (sub == SUB_REG_CFG && rd_sel == 2'h0) begin
      rd_byte = {6'h00, bridge_supply_regulator_sleep_off, bridge_supply_regulator_low};
    end else if (sub == SUB_ISENSE && rd_sel == 2'h0) begin
      rd_byte = {7'h00, current_sense_sel};
    end else if (sasc_is_offset(sub) && rd_sel == 2'h0) begin
      rd_byte = {5'h00, offset_mem[sub[3:0]][10:8]};
    end else if (sasc_is_offset(sub) && rd_sel == 2'h1) begin
      rd_byte = offset_mem[sub[3:0]][7:0];
    end
  end

  // ****************************************
  // protocol state machine
  // ****************************************
  // RULE4: start, address, data bytes, stop
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state   <= ST_IDLE;
      phase   <= PH_ADDR;
      bit_cnt <= 4'h0;
      shift   <= 8'h00;
      tx_sh   <= 8'h00;
      sda_oe  <= 1'b0;
      rd_idx  <= 2'h0;
      mack    <= 1'b0;
    end else if (ce) begin
      if (pins.start) begin
        state   <= ST_RX;
        phase   <= PH_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (pins.stop) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          ST_RX: begin
            if (pins.scl_rise && bit_cnt != BYTE_BITS) begin
              shift   <= {shift[6:0], pins.sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (pins.scl_fall && bit_cnt == BYTE_BITS) begin
              // RULE6: ack only a matching address
              if (phase == PH_ADDR && !addr_hit) begin
                state <= ST_WAIT;
              end else begin
                // RULE10: every written byte acknowledged
                state  <= ST_ACK;
                sda_oe <= 1'b1;
              end
            end
          end
          ST_ACK: begin
            if (pins.scl_fall) begin
              // RULE8: read direction goes to transmit
              if (phase == PH_ADDR && rw) begin
                state   <= ST_TX;
                tx_sh   <= rd_byte;
                sda_oe  <= !rd_byte[7];
                bit_cnt <= 4'h1;
                rd_idx  <= 2'h0;
              end else begin
                state   <= ST_RX;
                phase   <= (phase == PH_ADDR) ? PH_SUB : PH_PARAM;
                sda_oe  <= 1'b0;
                bit_cnt <= 4'h0;
              end
            end
          end
          ST_TX: begin
            if (pins.scl_fall) begin
              if (bit_cnt == BYTE_BITS) begin
                state  <= ST_MACK;
                sda_oe <= 1'b0;
              end else begin
                tx_sh   <= {tx_sh[6:0], 1'b0};
                sda_oe  <= !tx_sh[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (pins.scl_rise) begin
              mack <= !pins.sda_s;
            end else if (pins.scl_fall) begin
              // RULE25: continue on ack, stop on not-ack
              if (mack) begin
                state   <= ST_TX;
                tx_sh   <= rd_byte;
                sda_oe  <= !rd_byte[7];
                bit_cnt <= 4'h1;
                rd_idx  <= rd_sel;
              end else begin
                state <= ST_WAIT;
              end
            end
          end
          ST_IDLE, ST_WAIT: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // address, sub-address and parameter capture
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rw        <= 1'b0;
      sub       <= 8'h00;
      param_idx <= 2'h0;
      pbuf      <= 8'h00;
    end else if (ce) begin
      if (byte_done && phase == PH_ADDR && addr_hit) begin
        rw <= shift[0];
      end
      if (sub_done) begin
        sub       <= shift;
        param_idx <= 2'h0;
      end else if (par_done) begin
        pbuf      <= shift;
        param_idx <= (param_idx == 2'h3) ? param_idx : param_idx + 2'h1;
      end
    end
  end

  // ****************************************
  // configuration
  // ****************************************
  // RULE13: channel 1 after power-up
  // RULE23: regulator 3 V after power-up
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_channel                    <= RST_CHANNEL;
      programmable_gain_amp_code        <= RST_GAIN;
      bridge_supply_regulator_low       <= RST_REG_LOW;
      bridge_supply_regulator_sleep_off <= RST_REG_OFF;
      current_sense_sel                 <= RST_ISENSE;
      analog_power_down                 <= RST_SLEEP;
      init_done                         <= 1'b0;
    end else if (ce) begin
      // RULE26: reset command restores defaults
      if (reset_cmd) begin
        active_channel                    <= RST_CHANNEL;
        programmable_gain_amp_code        <= RST_GAIN;
        bridge_supply_regulator_low       <= RST_REG_LOW;
        bridge_supply_regulator_sleep_off <= RST_REG_OFF;
        current_sense_sel                 <= RST_ISENSE;
        analog_power_down                 <= RST_SLEEP;
        init_done                         <= 1'b1;
      end else if (sub_done) begin
        // RULE14: channel select needs no parameter
        // RULE24: unassigned numbers fall through
        if (shift[7:4] == SUB_CH_NIB) begin
          active_channel <= shift[3:0];
        end else if (shift == SUB_SLEEP) begin
          // RULE20: analog down, serial stays alive
          analog_power_down <= 1'b1;
        end else if (shift == SUB_WAKE) begin
          analog_power_down <= 1'b0;
        end
      end else if (par_done && param_idx == 2'h0) begin
        // RULE21: gain code in low three bits
        // RULE16: eight gain codes
        if (sub == SUB_GAIN) begin
          programmable_gain_amp_code <= shift[2:0];
        end else if (sub == SUB_REG_CFG) begin
          // RULE17: 3 V or 2.65 V
          bridge_supply_regulator_low       <= shift[REG_LOW_BIT];
          bridge_supply_regulator_sleep_off <= shift[REG_SLEEP_BIT];
        end else if (sub == SUB_ISENSE) begin
          // RULE19: current sense selector
          current_sense_sel <= shift[ISENSE_BIT];
        end
      end
    end
  end

  // ****************************************
  // offset store
  // ****************************************
  // RULE22: sign and magnitude, high byte first
  always_ff @(posedge ref_clk) begin
    if (!rst_n || (ce && reset_cmd)) begin
      for (int i = 0; i < 16; i++) begin
        offset_mem[i] <= RST_OFFSET;
      end
    end else if (ce && par_done && param_idx == 2'h1 && sasc_is_offset(sub)) begin
      offset_mem[sub[3:0]] <= {pbuf[2:0], shift};
    end
  end

  // ****************************************
  // analog controls
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      active_offset              <= RST_OFFSET;
      bridge_supply_regulator_en <= 1'b1;
      sda_out                    <= 1'b0;
    end else if (ce) begin
      // RULE15: only the active channel offset applies
      active_offset              <= offset_mem[active_channel];
      // RULE18: optional regulator off in sleep
      bridge_supply_regulator_en <= !(analog_power_down && bridge_supply_regulator_sleep_off);
      sda_out                    <= 1'b0;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  start_enter_a: assert property ( // RULE5
    @(posedge ref_clk) disable iff (!rst_n)
    ce && pins.start |=> state == ST_RX && phase == PH_ADDR && bit_cnt == 4'h0 && !sda_oe)
    else $error("start did not open an address byte");

  stop_idle_a: assert property ( // RULE11
    @(posedge ref_clk) disable iff (!rst_n)
    ce && pins.stop && !pins.start |=> state == ST_IDLE && !sda_oe)
    else $error("stop did not return to idle");

  addr_ack_a: assert property ( // RULE6
    @(posedge ref_clk) disable iff (!rst_n)
    byte_done && phase == PH_ADDR |=> sda_oe == ($past(shift[7:1]) == SLAVE_ADDR))
    else $error("address acknowledge wrong");

  ack_hold_a: assert property ( // RULE10
    @(posedge ref_clk) disable iff (!rst_n)
    ce && state == ST_ACK && !pins.scl_fall && !pins.start && !pins.stop |=> sda_oe)
    else $error("acknowledge released early");

  chan_sel_a: assert property ( // RULE14
    @(posedge ref_clk) disable iff (!rst_n)
    sub_done && shift[7:4] == 4'h1 |=> active_channel == $past(shift[3:0]))
    else $error("channel select not applied");

  gain_set_a: assert property ( // RULE21
    @(posedge ref_clk) disable iff (!rst_n)
    par_done && param_idx == 2'h0 && sub == 8'h06 |=>
      programmable_gain_amp_code == $past(shift[2:0]))
    else $error("gain not applied");

  offset_apply_a: assert property ( // RULE15
    @(posedge ref_clk) disable iff (!rst_n)
    ce ##1 ce |-> active_offset == $past(offset_mem[active_channel]))
    else $error("active offset does not follow channel");

  reg_sleep_a: assert property ( // RULE18
    @(posedge ref_clk) disable iff (!rst_n)
    ce && analog_power_down && bridge_supply_regulator_sleep_off |=> !bridge_supply_regulator_en)
    else $error("regulator on in sleep");

  reset_cmd_a: assert property ( // RULE26
    @(posedge ref_clk) disable iff (!rst_n)
    reset_cmd |=> active_channel == 4'h0 && programmable_gain_amp_code == 3'h0 &&
                  !bridge_supply_regulator_low && !analog_power_down && init_done)
    else $error("reset command left state");

  unmapped_a: assert property ( // RULE24
    @(posedge ref_clk) disable iff (!rst_n)
    sub_done && shift == 8'h00 |=> $stable(active_channel) && $stable(analog_power_down) &&
                                   $stable(programmable_gain_amp_code))
    else $error("unassigned sub-address changed state");

  tx_msb_a: assert property ( // RULE25
    @(posedge ref_clk) disable iff (!rst_n)
    state == ST_TX |-> sda_oe == !tx_sh[7])
    else $error("read bit not driven from shifter msb");

  addr_ack_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    byte_done && phase == PH_ADDR && addr_hit);
  chan_sel_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    sub_done && shift[7:4] == SUB_CH_NIB);
  offset_wr_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    par_done && param_idx == 2'h1 && sasc_is_offset(sub));
  read_nack_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    ce && state == ST_MACK && pins.scl_fall && !mack);

endmodule // sasc_serial_ctrl
